// >>> verilog/csf_pkg.sv
// codec serial frame interface: shared constants, types and register map
// assumes a 32-bit apb slave port and a single 20 MHz system clock
package csf_pkg;
	// register byte offsets
	localparam logic [7:0]  CSF_CTRL_ONE_OFS  = 8'h00;
	localparam logic [7:0]  CSF_CTRL_TWO_OFS  = 8'h04;
	localparam logic [7:0]  CSF_STATUS_OFS    = 8'h08;
	localparam logic [7:0]  CSF_TXBUF_OFS     = 8'h10;
	localparam logic [7:0]  CSF_RXBUF_OFS     = 8'h20;
	// control_one_reg fields
	localparam int          CSF_EN_BIT        = 0;
	localparam int          CSF_FSDIR_BIT     = 1;
	localparam int          CSF_IDLE_BIT      = 2;
	localparam int          CSF_FSMODE_LSB    = 3;
	localparam int          CSF_DIV_LSB       = 16;
	// control_two_reg fields
	localparam int          CSF_CKDIR_BIT     = 0;
	localparam int          CSF_WS_LSB        = 4;
	localparam int          CSF_FL_LSB        = 8;
	// reset values
	localparam logic [31:0] CSF_CTRL_ONE_RST  = 32'h0000_0000;
	localparam logic [31:0] CSF_CTRL_TWO_RST  = 32'h0000_00f0;
	// ac-link framing figures
	localparam logic [4:0]  CSF_AC_WORD_LEN   = 5'h10;
	localparam logic [8:0]  CSF_AC_FRAME_LEN  = 9'h100;
	localparam logic [7:0]  CSF_AC_SYNC_HIGH  = 8'h10;

	typedef enum logic [1:0] {
		CSF_MODE_MULTI = 2'h0,
		CSF_MODE_I2S   = 2'h1,
		CSF_MODE_AC16  = 2'h2,
		CSF_MODE_AC20  = 2'h3
	} csf_fsmode_e;

	typedef enum logic [1:0] {
		CSF_ST_IDLE  = 2'h1,
		CSF_ST_FRAME = 2'h2
	} csf_state_e;

	typedef struct packed {
		logic        module_enable_bit;
		logic        frame_sync_direction;
		logic        idle_output_mode;
		csf_fsmode_e frame_sync_mode_field;
		logic [11:0] clock_divider;
		logic        bit_clock_direction;
		logic [3:0]  word_size_field;
		logic [3:0]  frame_length_field;
	} csf_cfg_s;

	typedef struct packed {
		logic bit_clock_o;
		logic bit_clock_oe_n;
		logic serial_out_o;
		logic serial_out_oe_n;
		logic frame_sync_o;
		logic frame_sync_oe_n;
	} csf_pins_s;
endpackage : csf_pkg

// >>> verilog/csf_codec_serial.sv
// codec serial frame interface: apb registers, shadow buffers, framing
// assumes pins pass through pads that resolve level from the oe_n outputs
//
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/1ps
module csf_codec_serial (
	// clock and reset
	input  wire logic                clk,
	input  wire logic                reset,
	// apb slave
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [7:0]          paddr,
	input  wire logic [31:0]         pwdata,
	output logic                     pready,
	output logic [31:0]              prdata,
	output logic                     pslverr,
	// link pins
	input  wire logic                bit_clock_pin_i,
	input  wire logic                serial_in_pin,
	input  wire logic                frame_sync_pin_i,
	output csf_pkg::csf_pins_s       pins
);
	import csf_pkg::*;

	logic [31:0] ctrl_one_ff;
	logic [31:0] ctrl_two_ff;
	logic [15:0] buf_mem [0:7];
	logic [31:0] prdata_ff;
	logic        pslverr_ff;
	csf_cfg_s    cfg;

	assign cfg.module_enable_bit     = ctrl_one_ff[CSF_EN_BIT];
	assign cfg.frame_sync_direction  = ctrl_one_ff[CSF_FSDIR_BIT];
	assign cfg.idle_output_mode      = ctrl_one_ff[CSF_IDLE_BIT];
	assign cfg.frame_sync_mode_field = csf_fsmode_e'(ctrl_one_ff[CSF_FSMODE_LSB +: 2]);
	assign cfg.clock_divider         = ctrl_one_ff[CSF_DIV_LSB +: 12];
	assign cfg.bit_clock_direction   = ctrl_two_ff[CSF_CKDIR_BIT];
	assign cfg.word_size_field       = ctrl_two_ff[CSF_WS_LSB +: 4];
	assign cfg.frame_length_field    = ctrl_two_ff[CSF_FL_LSB +: 4];

	// ---------------- apb decode ----------------
	wire       bus_setup  = psel & ~penable;
	wire       bus_write  = psel & penable & pwrite;
	wire       hit_one    = paddr == CSF_CTRL_ONE_OFS;
	wire       hit_two    = paddr == CSF_CTRL_TWO_OFS;
	wire       hit_stat   = paddr == CSF_STATUS_OFS;
	wire       hit_tx     = paddr[7:4] == CSF_TXBUF_OFS[7:4] && paddr[1:0] == 2'h0;
	wire       hit_rx     = paddr[7:4] == CSF_RXBUF_OFS[7:4] && paddr[1:0] == 2'h0;
	wire       hit_any    = hit_one | hit_two | hit_stat | hit_tx | hit_rx;
	wire [2:0] cpu_tx_adr = {1'b1, paddr[3:2]};
	wire [2:0] cpu_rx_adr = {1'b0, paddr[3:2]};

	// ---------------- pin synchronisers ----------------
	logic [2:0] sync1_ff;
	logic [2:0] sync2_ff;
	always_ff @(posedge clk) begin
		sync1_ff <= {frame_sync_pin_i, serial_in_pin, bit_clock_pin_i};
		sync2_ff <= sync1_ff;
	end
	wire ck_pin_s = sync2_ff[0];
	wire din_s    = sync2_ff[1];
	wire fs_pin_s = sync2_ff[2];

	// ---------------- bit clock generator ----------------
	logic [11:0] div_cnt_ff;
	logic        gen_ck_ff;
	wire         gen_on   = cfg.clock_divider != 12'h000;
	wire         div_wrap = div_cnt_ff == cfg.clock_divider;
	always_ff @(posedge clk) begin
		if (reset || !gen_on) begin
			div_cnt_ff <= 12'h000;
			gen_ck_ff  <= 1'b0;
		end else if (div_wrap) begin
			div_cnt_ff <= 12'h000;
			gen_ck_ff  <= ~gen_ck_ff;
		end else begin
			div_cnt_ff <= div_cnt_ff + 12'h001;
		end
	end

	// ---------------- bit clock edges ----------------
	logic ck_prev_ff;
	wire  ck_lvl = cfg.bit_clock_direction ? ck_pin_s : gen_ck_ff;
	wire  run    = cfg.module_enable_bit;
	always_ff @(posedge clk) begin
		if (reset || !run) begin
			ck_prev_ff <= 1'b0;
		end else begin
			ck_prev_ff <= ck_lvl;
		end
	end
	wire ck_rise = run & ck_lvl & ~ck_prev_ff;
	wire ck_fall = run & ~ck_lvl & ck_prev_ff;

	// ---------------- frame geometry ----------------
	wire       is_ac     = cfg.frame_sync_mode_field == CSF_MODE_AC16 ||
	                       cfg.frame_sync_mode_field == CSF_MODE_AC20;
	wire       is_i2s    = cfg.frame_sync_mode_field == CSF_MODE_I2S;
	wire       is_master = ~cfg.frame_sync_direction;
	wire [3:0] wlast     = is_ac ? 4'hf : cfg.word_size_field;
	wire [3:0] flast     = is_ac ? 4'hf : cfg.frame_length_field;
	wire [4:0] wlen      = is_ac ? CSF_AC_WORD_LEN : {1'b0, wlast} + 5'h01;
	wire [4:0] fwords    = {1'b0, flast} + 5'h01;
	wire [8:0] flen      = is_ac ? CSF_AC_FRAME_LEN : 9'(wlen) * 9'(fwords);
	wire [7:0] fbit_last = 8'(flen - 9'h001);
	wire [7:0] half_m1   = 8'(flen[8:1] - 8'h01);

	// ---------------- sequence state ----------------
	csf_state_e  state_ff;
	logic [3:0]  bit_cnt_ff;
	logic [3:0]  word_cnt_ff;
	logic [7:0]  fbit_ff;
	logic [1:0]  ptr_ff;
	logic [15:0] shift_ff;
	logic        din_smp_ff;
	logic        fs_smp_ff;
	logic        start_pend_ff;
	logic        sdo_ff;
	logic        tx_period_ff;
	logic        fs_out_ff;

	wire active    = state_ff == CSF_ST_FRAME;
	wire bit_end   = bit_cnt_ff == wlast;
	wire frame_end = bit_end && word_cnt_ff == flast;

	// slave sync detection on the sampling edge
	wire fs_seen   = is_i2s ? (fs_pin_s != fs_smp_ff) : fs_pin_s;
	wire start     = is_master ? ~active : start_pend_ff;
	wire finish    = ~is_master & active & frame_end & ~start;
	wire store     = active & bit_end;
	wire word_go   = start | (store & ~finish);

	wire [3:0] nxt_bit  = (start || bit_end) ? 4'h0 : bit_cnt_ff + 4'h1;
	wire [3:0] nxt_word = (start || frame_end) ? 4'h0 :
	                      (bit_end ? word_cnt_ff + 4'h1 : word_cnt_ff);
	wire [7:0] nxt_fbit = (start || frame_end) ? 8'h00 : fbit_ff + 8'h01;
	wire [1:0] nxt_ptr  = store ? ptr_ff + 2'h1 : ptr_ff;

	wire [15:0] rx_raw  = {shift_ff[14:0], din_smp_ff};
	wire [15:0] rx_word = rx_raw << (4'hf - wlast);
	wire [15:0] tx_word = buf_mem[{1'b1, nxt_ptr}];
	wire [2:0]  rx_adr  = {1'b0, ptr_ff};

	// master sync shape for the bit period that begins now
	wire fs_multi = nxt_fbit == fbit_last;
	wire fs_ac    = nxt_fbit == fbit_last || nxt_fbit < CSF_AC_SYNC_HIGH - 8'h01;
	wire fs_i2s   = nxt_fbit != fbit_last && nxt_fbit >= half_m1;
	wire nxt_fs   = is_ac ? fs_ac : (is_i2s ? fs_i2s : fs_multi);

	// sampling edge: data and sync captured
	always_ff @(posedge clk) begin
		if (reset || !run) begin
			din_smp_ff    <= 1'b0;
			fs_smp_ff     <= 1'b0;
			start_pend_ff <= 1'b0;
		end else if (ck_fall) begin
			din_smp_ff    <= din_s;
			fs_smp_ff     <= fs_pin_s;
			start_pend_ff <= 1'b0;
			if (!is_master && (!active || frame_end) && fs_seen) begin
				start_pend_ff <= 1'b1;
			end
		end else if (ck_rise && start) begin
			start_pend_ff <= 1'b0;
		end
	end

	// launch edge: counters, shift register, outputs
	always_ff @(posedge clk) begin
		if (reset || !run) begin
			state_ff     <= CSF_ST_IDLE;
			bit_cnt_ff   <= 4'h0;
			word_cnt_ff  <= 4'h0;
			fbit_ff      <= 8'h00;
			ptr_ff       <= 2'h0;
			shift_ff     <= 16'h0000;
			sdo_ff       <= 1'b0;
			tx_period_ff <= 1'b0;
			fs_out_ff    <= 1'b0;
		end else if (ck_rise) begin
			if (start) begin
				state_ff <= CSF_ST_FRAME;
			end else if (finish) begin
				state_ff <= CSF_ST_IDLE;
			end
			if (start || active) begin
				bit_cnt_ff  <= nxt_bit;
				word_cnt_ff <= nxt_word;
				fbit_ff     <= nxt_fbit;
			end
			ptr_ff <= nxt_ptr;
			if (word_go) begin
				shift_ff <= tx_word;
				sdo_ff   <= tx_word[15];
			end else begin
				shift_ff <= rx_raw;
				sdo_ff   <= shift_ff[14];
			end
			tx_period_ff <= start | (active & ~finish);
			fs_out_ff    <= is_master & (start | active) & nxt_fs;
		end
	end
	wire rx_we = ck_rise & store;

	// ---------------- apb registers and shadow memory ----------------
	always_ff @(posedge clk) begin
		if (reset) begin
			ctrl_one_ff <= CSF_CTRL_ONE_RST;
			ctrl_two_ff <= CSF_CTRL_TWO_RST;
		end else if (bus_write && hit_one) begin
			ctrl_one_ff <= pwdata;
		end else if (bus_write && hit_two) begin
			ctrl_two_ff <= pwdata;
		end
	end

	always_ff @(posedge clk) begin
		if (bus_write && hit_tx) begin
			buf_mem[cpu_tx_adr] <= pwdata[15:0];
		end
		if (rx_we) begin
			buf_mem[rx_adr] <= rx_word;
		end
	end

	wire [31:0] stat_word = {28'h0, gen_on, active, ptr_ff};
	wire [31:0] rd_data   = hit_one  ? ctrl_one_ff :
	                        hit_two  ? ctrl_two_ff :
	                        hit_stat ? stat_word :
	                        hit_tx   ? {16'h0000, buf_mem[cpu_tx_adr]} :
	                        hit_rx   ? {16'h0000, buf_mem[cpu_rx_adr]} : 32'h0000_0000;

	always_ff @(posedge clk) begin
		if (reset) begin
			prdata_ff  <= 32'h0000_0000;
			pslverr_ff <= 1'b0;
		end else if (bus_setup) begin
			prdata_ff  <= pwrite ? 32'h0000_0000 : rd_data;
			pslverr_ff <= ~hit_any;
		end
	end
	assign pready  = psel & penable;
	assign prdata  = prdata_ff;
	assign pslverr = pslverr_ff;

	// ---------------- pin drive ----------------
	assign pins.bit_clock_o     = gen_ck_ff;
	assign pins.bit_clock_oe_n  = ~(gen_on & ~cfg.bit_clock_direction);
	assign pins.serial_out_o    = run & tx_period_ff & sdo_ff;
	assign pins.serial_out_oe_n = ~run | (~tx_period_ff & cfg.idle_output_mode);
	assign pins.frame_sync_o    = fs_out_ff;
	assign pins.frame_sync_oe_n = ~(run & is_master);
endmodule : csf_codec_serial

// >>> testbench/csf_codec_serial_sva.sv
// checker: pin ownership and frame sync timing of csf_codec_serial
// assumes config changes only through apb writes
`timescale 1ns/1ps
module csf_codec_serial_chk (
	// clock and reset
	input wire logic               clk,
	input wire logic               reset,
	// apb
	input wire logic               psel,
	input wire logic               penable,
	input wire logic               pwrite,
	input wire logic [7:0]         paddr,
	input wire logic [31:0]        pwdata,
	input wire logic               pready,
	input wire logic [31:0]        prdata,
	input wire logic               pslverr,
	// link pins
	input wire logic               bit_clock_pin_i,
	input wire logic               serial_in_pin,
	input wire logic               frame_sync_pin_i,
	input wire csf_pkg::csf_pins_s pins
);
	import csf_pkg::*;
	logic        en_ff, fsd_ff, idle_ff, ckd_ff, fsp_ff, bkp_ff;
	logic [1:0]  mode_ff, st_ff, vld_ff;
	logic [3:0]  ws_ff, fl_ff;
	logic [11:0] div_ff;
	logic [8:0]  cnt_ff;
	wire         wr_en  = psel && penable && pwrite && pready;
	wire         steady = st_ff == 2'h3;
	wire         tog    = pins.frame_sync_o != fsp_ff;
	wire [8:0]   bits   = ({5'h0, ws_ff} + 9'h1) * ({5'h0, fl_ff} + 9'h1);
	always_ff @(posedge clk) begin
		fsp_ff <= pins.frame_sync_o;
		bkp_ff <= pins.bit_clock_o;
		cnt_ff <= (tog ? 9'h0 : cnt_ff) + {8'h0, pins.bit_clock_o && !bkp_ff};
		st_ff  <= (wr_en && paddr < 8'h08) ? 2'h0 : st_ff + {1'b0, !steady};
		vld_ff <= (steady && en_ff && !fsd_ff) ? vld_ff + {1'b0, tog && vld_ff != 2'h2} : 2'h0;
		if (wr_en && paddr == CSF_CTRL_ONE_OFS)
			{div_ff, mode_ff, idle_ff, fsd_ff, en_ff} <= {pwdata[27:16], pwdata[4:0]};
		if (wr_en && paddr == CSF_CTRL_TWO_OFS)
			{fl_ff, ws_ff, ckd_ff} <= {pwdata[11:4], pwdata[0]};
		if (reset) begin
			{div_ff, mode_ff, idle_ff, fsd_ff, en_ff, fl_ff, ckd_ff, st_ff, vld_ff} <= '0;
			ws_ff <= 4'hf;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	a_pins_off: assert property (
		steady && !en_ff |-> pins.serial_out_oe_n && pins.frame_sync_oe_n)
		else $error("pins driven while disabled");
	a_fs_dir: assert property (steady && en_ff |-> pins.frame_sync_oe_n == fsd_ff)
		else $error("frame sync direction wrong");
	a_out_drive: assert property (
		steady && en_ff && !idle_ff && !wr_en |-> !pins.serial_out_oe_n [*2])
		else $error("serial out not driven");
	a_bck_owner: assert property (
		steady |-> pins.bit_clock_oe_n == (div_ff == 12'h0 || ckd_ff))
		else $error("bit clock ownership wrong");
	a_ac_shape: assert property (
		vld_ff == 2'h2 && mode_ff[1] && tog |-> cnt_ff == (pins.frame_sync_o ? 9'd240 : 9'd16))
		else $error("ac sync shape wrong");
	a_mc_pulse: assert property (
		vld_ff == 2'h2 && mode_ff == 2'h0 && $fell(pins.frame_sync_o) |-> cnt_ff == 9'd1)
		else $error("multi sync width wrong");
	a_mc_gap: assert property (
		vld_ff == 2'h2 && mode_ff == 2'h0 && $rose(pins.frame_sync_o) |-> cnt_ff == bits - 9'd1)
		else $error("multi frame length wrong");
	a_i2s_half: assert property (
		vld_ff == 2'h2 && mode_ff == 2'h1 && tog |-> cnt_ff == bits >> 1)
		else $error("i2s half period wrong");
endmodule : csf_codec_serial_chk
bind csf_codec_serial csf_codec_serial_chk u_chk (.clk, .reset, .psel, .penable, .pwrite, .paddr,
	.pwdata, .pready, .prdata, .pslverr, .bit_clock_pin_i, .serial_in_pin, .frame_sync_pin_i, .pins);

// >>> testbench/csf_codec_model.sv
// codec model: shifts a fixed pattern in, captures serial out
// assumes resolved pin levels; ext makes it clock and sync master
`timescale 1ns/1ps
module csf_codec_model #(
	parameter logic [15:0] PAT = 16'hb6e1
) (
	// clock and reset
	input wire logic    clk,
	input wire logic    reset,
	// link lines
	input wire logic    ext,
	input wire logic    bck,
	input wire logic    fs,
	input wire logic    sdo,
	output logic        bck_ff,
	output logic        fs_ff,
	output logic        sdi_ff,
	// last bits seen on serial out
	output logic [15:0] frame_ff
);
	logic        bprev_ff, fprev_ff, pend_ff, odd_ff;
	logic [1:0]  div_ff;
	logic [4:0]  idx_ff;
	logic [15:0] cap_ff;
	wire         start = ext ? idx_ff[3] : pend_ff;
	always_ff @(posedge clk) begin
		bprev_ff <= bck;
		div_ff   <= div_ff + 2'h1;
		if (!ext) begin
			bck_ff <= ~bck_ff;
			fs_ff  <= ~fs_ff;
		end else if (div_ff == 2'h3)
			bck_ff <= ~bck_ff;
		if (bck && !bprev_ff) begin
			idx_ff <= start ? 5'h1 : idx_ff + 5'h1;
			sdi_ff <= PAT[start ? 4'hf : ~idx_ff[3:0]];
			if (start) begin
				frame_ff <= cap_ff;
				odd_ff   <= ~odd_ff;
			end
			// stray mid-frame sync only every other frame, so no false lock
			if (ext)
				fs_ff <= idx_ff == 5'h7 || (idx_ff == 5'h3 && odd_ff);
		end
		if (!bck && bprev_ff) begin
			cap_ff   <= {cap_ff[14:0], sdo};
			pend_ff  <= fs && !fprev_ff;
			fprev_ff <= fs;
		end
		if (reset)
			{bprev_ff, fprev_ff, pend_ff, odd_ff, div_ff, idx_ff, cap_ff, bck_ff, fs_ff, frame_ff} <= '0;
	end
endmodule : csf_codec_model

// >>> testbench/csf_codec_serial_tb.sv
// bench for csf_codec_serial with codec model
// assumes pins resolve from oe_n; apb master here
`timescale 1ns/1ps
module csf_codec_serial_tb;
	import csf_pkg::*;
	logic        clk, reset, psel, penable, pwrite, ext, pready, pslverr;
	logic        err_q, bck_ff, fs_ff, sdi_ff;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd_q;
	logic [15:0] frame_ff;
	csf_pins_s   pins;
	int          n_mismatch, cmp_count, cyc;
	wire         bck_w = pins.bit_clock_oe_n ? bck_ff : pins.bit_clock_o;
	wire         fs_w  = pins.frame_sync_oe_n ? fs_ff : pins.frame_sync_o;
	wire         sdo_w = pins.serial_out_o ^ pins.serial_out_oe_n;
	csf_codec_serial uut (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
		.prdata, .pslverr, .bit_clock_pin_i(bck_w), .serial_in_pin(sdi_ff),
		.frame_sync_pin_i(fs_w), .pins);
	csf_codec_model codec (.clk, .reset, .ext, .bck(bck_w), .fs(fs_w), .sdo(sdo_w), .bck_ff,
		.fs_ff, .sdi_ff, .frame_ff);
	always #25 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			n_mismatch++;
			print_verdict();
		end
	end
	task print_verdict;
		$display("checks %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : print_verdict
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd_q = prdata;
		err_q = pslverr;
		{psel, penable} <= 2'b00;
	endtask : apb
	task rx_chk(input logic [15:0] r0, input logic [15:0] r1);
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, CSF_RXBUF_OFS + 8'(4 * i), 32'h0);
			chk(rd_q, {16'h0, i[0] ? r1 : r0});
		end
	endtask : rx_chk
	task test_regs;
		apb(1'b0, CSF_CTRL_TWO_OFS, 32'h0);
		chk(rd_q, 32'h0000_00f0);
		apb(1'b0, 8'h40, 32'h0);
		chk({rd_q[31:1], err_q}, 32'h1);
		for (int i = 0; i < 4; i++)
			apb(1'b1, CSF_TXBUF_OFS + 8'(4 * i), i[0] ? 32'h3fff : 32'ha5c3);
		$display("regs done");
	endtask : test_regs
	task test_run(input logic [1:0] m, input int n, input logic [15:0] r0, r1, fq, input logic x);
		ext <= x;
		apb(1'b1, CSF_CTRL_ONE_OFS, 32'h0);
		apb(1'b1, CSF_CTRL_TWO_OFS, {31'h98, x});
		apb(1'b1, CSF_CTRL_ONE_OFS, x ? 32'h7 : {16'h3, 11'h0, m, 3'h1});
		@(negedge clk);
		chk({31'h0, pins.serial_out_oe_n}, {31'h0, x});
		repeat (n) @(posedge clk);
		if (m != CSF_MODE_I2S) begin
			rx_chk(r0, r1);
			chk({16'h0, frame_ff}, {16'h0, fq});
		end
		apb(1'b1, CSF_CTRL_ONE_OFS, 32'h0);
		apb(1'b0, CSF_STATUS_OFS, 32'h0);
		chk(rd_q, 32'h0);
		$display("mode %0d slave %0d done", m, x);
	endtask : test_run
	initial begin
		{clk, psel, penable, pwrite, ext, paddr, pwdata} = '0;
		reset = 1'b1;
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		test_regs();
		test_run(CSF_MODE_MULTI, 800, 16'hb000, 16'h6000, 16'ha3a3, 1'b0);
		test_run(CSF_MODE_I2S, 800, 16'h0, 16'h0, 16'h0, 1'b0);
		test_run(CSF_MODE_AC16, 7000, 16'hb6e1, 16'hb6e1, 16'h3fff, 1'b0);
		test_run(CSF_MODE_AC20, 7000, 16'hb6e1, 16'hb6e1, 16'h3fff, 1'b0);
		test_run(CSF_MODE_MULTI, 900, 16'hb000, 16'h6000, 16'ha3a3, 1'b1);
		print_verdict();
	end
endmodule : csf_codec_serial_tb
